// ### core/swi_sleep_wake_irq_control.sv
/*
 * Sleep/wake gating of event functions, interrupt pin drive and FIFO gate control.
 * Assumes event, sleep, rate and FIFO signals come from logic on the same clock.
 */
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module swi_sleep_wake_irq_control
  import swi_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [SWI_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [SWI_DW-1:0] wb_dat_i,
  output logic [SWI_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic sleep_mode,
  input wire logic [SWI_RATE_W-1:0] output_sample_rate,
  input wire logic [SWI_NFUNC-1:0] func_event,
  input wire logic irq_one_pending,
  input wire logic irq_two_pending,
  input wire logic sample_valid,
  input wire logic fifo_empty,
  output logic sample_write,
  output logic fifo_flush,
  output logic debounce_reset,
  output logic [SWI_NFUNC-1:0] func_active,
  output logic wake_request,
  output logic irq_line_one_o,
  output logic irq_line_one_oe,
  output logic irq_line_two_o,
  output logic irq_line_two_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  swi_ctrl_t ctrl_ff, nxt_ctrl;
  logic aslp_en_ff, nxt_aslp_en;
  logic [SWI_NIRQ-1:0] istat_ff, nxt_istat;
  logic [SWI_NIRQ-1:0] imask_ff, nxt_imask;
  logic wb_ack_ff, nxt_wb_ack;
  logic [SWI_DW-1:0] wb_dat_ff, nxt_wb_dat;
  logic irq_ff, nxt_irq;
  logic [SWI_NIRQ-1:0] irq_set;
  swi_gate_t gate_ff, nxt_gate;
  logic sleep_ff;

  logic bus_req;
  logic wr_lane0;

  always_comb begin
    bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
    wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
    nxt_wb_ack = bus_req;
    nxt_ctrl = ctrl_ff;
    nxt_aslp_en = aslp_en_ff;
    nxt_imask = imask_ff;
    nxt_wb_dat = wb_dat_ff;
    // Read data is cleared after the ack so stale values never linger on the bus.
    if (wb_ack_ff) begin
      nxt_wb_dat = '0;
    end
    if (wr_lane0) begin
      case (wb_adr_i)
        SWI_ADDR_CTRL: begin
          nxt_ctrl = swi_ctrl_t'(wb_dat_i[7:0]);
        end
        SWI_ADDR_IMASK: begin
          nxt_imask = wb_dat_i[SWI_NIRQ-1:0];
        end
        SWI_ADDR_CFG: begin
          nxt_aslp_en = wb_dat_i[SWI_CFG_ASLP];
        end
        default: begin
        end
      endcase
    end
    if (bus_req & ~wb_we_i) begin
      nxt_wb_dat = '0;
      case (wb_adr_i)
        SWI_ADDR_CTRL: begin
          nxt_wb_dat[7:0] = ctrl_ff;
        end
        SWI_ADDR_ISTAT: begin
          nxt_wb_dat[SWI_NIRQ-1:0] = istat_ff;
        end
        SWI_ADDR_IMASK: begin
          nxt_wb_dat[SWI_NIRQ-1:0] = imask_ff;
        end
        SWI_ADDR_STATE: begin
          nxt_wb_dat[SWI_ST_GERR] = (gate_ff == SWI_GATE_ERR);
          nxt_wb_dat[SWI_ST_HELD] = (gate_ff != SWI_GATE_OPEN);
          nxt_wb_dat[SWI_ST_SLEEP] = sleep_ff;
        end
        SWI_ADDR_CFG: begin
          nxt_wb_dat[SWI_CFG_ASLP] = aslp_en_ff;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_ff <= swi_ctrl_t'(SWI_CTRL_RST);
      aslp_en_ff <= 1'b0;
      imask_ff <= SWI_IRQ_RST;
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      aslp_en_ff <= nxt_aslp_en;
      imask_ff <= nxt_imask;
      wb_ack_ff <= nxt_wb_ack;
      wb_dat_ff <= nxt_wb_dat;
    end
  end

  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, read to clear; a set in the clearing cycle survives.

  logic istat_rd;

  always_comb begin
    istat_rd = bus_req & ~wb_we_i & (wb_adr_i == SWI_ADDR_ISTAT);
    nxt_istat = istat_ff;
    if (istat_rd) begin
      nxt_istat = '0;
    end
    nxt_istat = nxt_istat | irq_set;
    nxt_irq = |(nxt_istat & imask_ff);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      istat_ff <= SWI_IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      istat_ff <= nxt_istat;
      irq_ff <= nxt_irq;
    end
  end

  assign irq_o = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep/Wake gating of the event functions.

  logic [SWI_NFUNC-1:0] func_active_ff, nxt_func_active;
  logic wake_req_ff, nxt_wake_req;
  logic [SWI_NFUNC-1:0] wake_hit;

  generate
    for (genvar f = 0; f < SWI_NFUNC; f++) begin : g_func
      always_comb begin
        // A function runs while awake, and in Sleep only if its wake bit is set.
        nxt_func_active[f] = ~sleep_mode | ctrl_ff.wake_en[f];
        wake_hit[f] = sleep_mode & ctrl_ff.wake_en[f] & func_event[f];
      end
    end
  endgenerate

  always_comb begin
    nxt_wake_req = |wake_hit;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      func_active_ff <= '1;
      wake_req_ff <= 1'b0;
    end else begin
      func_active_ff <= nxt_func_active;
      wake_req_ff <= nxt_wake_req;
    end
  end

  assign func_active = func_active_ff;
  assign wake_request = wake_req_ff;

  ////////////////////////////////////////////////////////////////////////////
  // FIFO flush and gate.

  logic [SWI_RATE_W-1:0] rate_ff;
  logic flush_ff, nxt_flush;
  logic dbr_ff, nxt_dbr;
  logic swr_ff, nxt_swr;
  logic mode_change;
  logic rate_change;

  always_comb begin
    mode_change = sleep_mode ^ sleep_ff;
    rate_change = output_sample_rate != rate_ff;
    nxt_gate = gate_ff;
    nxt_dbr = mode_change & aslp_en_ff;
    // The hold bit overrides the auto-sleep flush so that held data is kept.
    nxt_flush = rate_change
      | (mode_change & ~ctrl_ff.fifo_hold);
    case (gate_ff)
      SWI_GATE_OPEN: begin
        if (mode_change & ctrl_ff.fifo_hold & ~fifo_empty & ~rate_change) begin
          nxt_gate = SWI_GATE_HELD;
        end
      end
      SWI_GATE_HELD: begin
        if (fifo_empty | rate_change) begin
          nxt_gate = SWI_GATE_OPEN;
        end else if (sample_valid) begin
          nxt_gate = SWI_GATE_ERR;
        end
      end
      SWI_GATE_ERR: begin
        if (fifo_empty | rate_change) begin
          nxt_gate = SWI_GATE_OPEN;
        end
      end
      default: begin
        nxt_gate = SWI_GATE_OPEN;
      end
    endcase
    // Samples are refused while held, in the cycle the gate closes and in the cycle a flush is issued.
    // A sample that meets the transition itself would otherwise slip in behind the held data.
    nxt_swr = sample_valid & (gate_ff == SWI_GATE_OPEN) & (nxt_gate == SWI_GATE_OPEN) & ~nxt_flush;
    irq_set = '0;
    irq_set[SWI_IRQ_WAKE] = nxt_wake_req;
    irq_set[SWI_IRQ_GERR] = (nxt_gate == SWI_GATE_ERR) & (gate_ff != SWI_GATE_ERR);
    irq_set[SWI_IRQ_FLUSH] = nxt_flush;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sleep_ff <= 1'b0;
      rate_ff <= '0;
      gate_ff <= SWI_GATE_OPEN;
      flush_ff <= 1'b0;
      dbr_ff <= 1'b0;
      swr_ff <= 1'b0;
    end else begin
      sleep_ff <= sleep_mode;
      rate_ff <= output_sample_rate;
      gate_ff <= nxt_gate;
      flush_ff <= nxt_flush;
      dbr_ff <= nxt_dbr;
      swr_ff <= nxt_swr;
    end
  end

  assign fifo_flush = flush_ff;
  assign debounce_reset = dbr_ff;
  assign sample_write = swr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin drive.

  swi_pin_t pin_one_ff, nxt_pin_one;
  swi_pin_t pin_two_ff, nxt_pin_two;

  function automatic swi_pin_t swi_drive(input logic pend, input swi_ctrl_t c);
    swi_pin_t p;
    p.o = pend ~^ c.irq_polarity;
    p.oe = 1'b1;
    if (c.irq_output_drive_type) begin
      // Open drain: only the asserted level is driven, else released.
      p.o = c.irq_polarity;
      p.oe = pend;
    end
    return p;
  endfunction

  always_comb begin
    nxt_pin_one = swi_drive(irq_one_pending, ctrl_ff);
    nxt_pin_two = swi_drive(irq_two_pending, ctrl_ff);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      // Reset value is push-pull, active low, deasserted.
      pin_one_ff <= '{o: 1'b1, oe: 1'b1};
      pin_two_ff <= '{o: 1'b1, oe: 1'b1};
    end else begin
      pin_one_ff <= nxt_pin_one;
      pin_two_ff <= nxt_pin_two;
    end
  end

  assign irq_line_one_o = pin_one_ff.o;
  assign irq_line_one_oe = pin_one_ff.oe;
  assign irq_line_two_o = pin_two_ff.o;
  assign irq_line_two_oe = pin_two_ff.oe;

endmodule

`default_nettype wire

// ### core/swi_pkg.sv
/*
 * Constants, register map and types of the sleep/wake interrupt control block.
 * Assumes a 32-bit classic Wishbone bus with byte addresses and a 100 MHz clock.
 */
// Behaviour
// - Hold bit clear: any Sleep/Wake transition flushes the whole FIFO.
// - Hold bit set: transition keeps FIFO contents, refuses samples until host empties it.
// - Held FIFO still unemptied when a sample arrives sets gate error, held while unemptied.
// - Host clears gate error by emptying the FIFO; device then drops the flag.
// - Transient wake bit keeps transient detection running and waking during Sleep.
// - Orientation wake bit keeps orientation detection running and waking during Sleep.
// - Tap wake bit keeps tap detection running and waking during Sleep.
// - Freefall/motion wake bit keeps that detection running and waking during Sleep.
// - Vector-magnitude wake bit keeps that detector running and waking during Sleep.
// - Polarity bit: both interrupt pins active low at 0, active high at 1.
// - Drive bit: both interrupt pins push-pull at 0, open-drain at 1.
// - Any change of output sample rate flushes the FIFO.
// - Auto-sleep enabled: each transition resets debounce counters; it flushes the FIFO only while the hold bit is clear.
package swi_pkg;

  localparam int SWI_AW = 8;
  localparam int SWI_DW = 32;
  localparam int SWI_NFUNC = 5;
  localparam int SWI_RATE_W = 3;
  localparam int SWI_NIRQ = 3;

  // Byte addresses of the registers.
  localparam logic [SWI_AW-1:0] SWI_ADDR_CTRL = 8'h2c;
  localparam logic [SWI_AW-1:0] SWI_ADDR_ISTAT = 8'h30;
  localparam logic [SWI_AW-1:0] SWI_ADDR_IMASK = 8'h34;
  localparam logic [SWI_AW-1:0] SWI_ADDR_STATE = 8'h38;
  localparam logic [SWI_AW-1:0] SWI_ADDR_CFG = 8'h3c;

  localparam logic [7:0] SWI_CTRL_RST = 8'h00;
  localparam logic [SWI_NIRQ-1:0] SWI_IRQ_RST = 3'h0;

  // Interrupt status and mask bit positions.
  localparam int SWI_IRQ_WAKE = 0;
  localparam int SWI_IRQ_GERR = 1;
  localparam int SWI_IRQ_FLUSH = 2;

  // State register bit positions.
  localparam int SWI_ST_GERR = 0;
  localparam int SWI_ST_HELD = 1;
  localparam int SWI_ST_SLEEP = 2;

  // Configuration register bit position.
  localparam int SWI_CFG_ASLP = 0;

  // Function enable / event vector order.
  localparam int SWI_F_VECM = 0;
  localparam int SWI_F_FFMT = 1;
  localparam int SWI_F_TAP = 2;
  localparam int SWI_F_ORIENT = 3;
  localparam int SWI_F_TRANS = 4;

  typedef struct packed {
    logic fifo_hold;
    logic [SWI_NFUNC-1:0] wake_en;
    logic irq_polarity;
    logic irq_output_drive_type;
  } swi_ctrl_t;

  typedef struct packed {
    logic o;
    logic oe;
  } swi_pin_t;

  typedef enum logic [1:0] {
    SWI_GATE_OPEN = 2'b00,
    SWI_GATE_HELD = 2'b01,
    SWI_GATE_ERR = 2'b10
  } swi_gate_t;

endpackage

// ### bench/swi_host_model.sv
/* Host side model: keeps the FIFO fill count and resolves both interrupt lines.
   Assumes one clock shared with the block and a pull-up on each line. */
`timescale 1ns/1ns
`default_nettype none
module swi_host_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sample_write,
  input wire logic fifo_flush,
  input wire logic drain,
  input wire logic irq_line_one_o,
  input wire logic irq_line_one_oe,
  input wire logic irq_line_two_o,
  input wire logic irq_line_two_oe,
  output logic fifo_empty,
  output logic [5:0] fifo_count,
  output logic line_one,
  output logic line_two
);
  // A released line floats up to the pull-up level, never the last driven one.
  assign line_one = irq_line_one_oe ? irq_line_one_o : 1'b1;
  assign line_two = irq_line_two_oe ? irq_line_two_o : 1'b1;
  assign fifo_empty = (fifo_count == 6'h0);
  always @(posedge clock) begin
    if (!resetn || fifo_flush)
      fifo_count <= 6'h0;
    else if (drain && !fifo_empty)
      fifo_count <= fifo_count - 6'h1;
    else if (sample_write && fifo_count < 6'h20)
      fifo_count <= fifo_count + 6'h1;
  end
endmodule
`default_nettype wire

// ### bench/swi_sleep_wake_irq_control_assertions.sv
/* Checker of the sleep/wake interrupt control block.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module swi_chk
  import swi_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sleep_mode,
  input wire logic [SWI_RATE_W-1:0] output_sample_rate,
  input wire logic [SWI_NFUNC-1:0] func_event,
  input wire logic [SWI_NFUNC-1:0] func_active,
  input wire logic irq_one_pending,
  input wire logic irq_two_pending,
  input wire logic sample_valid,
  input wire logic sample_write,
  input wire logic fifo_flush,
  input wire logic debounce_reset,
  input wire logic wake_request,
  input wire logic irq_line_one_o,
  input wire logic irq_line_one_oe,
  input wire logic irq_line_two_o,
  input wire logic irq_line_two_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  rate_flush_a: assert property ($changed(output_sample_rate) |=> fifo_flush) else $error("no flush");
  wake_cause_a: assert property (wake_request |-> $past(sleep_mode && |(func_event & func_active)))
    else $error("bad wake");
  write_gate_a: assert property (sample_write |-> $past(sample_valid) && !fifo_flush) else $error("bad write");
  od_release_a: assert property (!irq_line_two_oe |-> !$past(irq_two_pending)) else $error("bad release");
  pin_level_a: assert property (irq_line_one_oe && irq_line_two_oe && $past(irq_one_pending != irq_two_pending)
    |-> irq_line_one_o != irq_line_two_o) else $error("bad pins");
  debounce_why_a: assert property (debounce_reset |-> $past(sleep_mode) != $past(sleep_mode, 2))
    else $error("bad debounce");
  flush_why_a: assert property (fifo_flush |-> $past(sleep_mode) != $past(sleep_mode, 2)
    || $past(output_sample_rate) != $past(output_sample_rate, 2)) else $error("bad flush");
  cover property (wake_request);
  cover property (debounce_reset);
  cover property (fifo_flush);
endmodule
`default_nettype wire

// ### bench/test_sleep_wake_irq_control.sv
/* Self-checking testbench of the sleep/wake interrupt control block.
   Assumes the host model and the checker files are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module test_sleep_wake_irq_control;
  import swi_pkg::*;
  logic clock = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq_o;
  logic [SWI_AW-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [SWI_DW-1:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic sleep_mode = 0, irq_one_pending = 0, irq_two_pending = 0, sample_valid = 0, drain = 0;
  logic [SWI_RATE_W-1:0] output_sample_rate = 3'h0;
  logic [SWI_NFUNC-1:0] func_event = 5'h0, func_active;
  logic fifo_empty, sample_write, fifo_flush, debounce_reset, wake_request, line_one, line_two;
  logic irq_line_one_o, irq_line_one_oe, irq_line_two_o, irq_line_two_oe;
  logic [5:0] fifo_count;
  int n_errors = 0, compares = 0;
  always #5 clock = ~clock;
  swi_sleep_wake_irq_control swi_sleep_wake_irq_control_i (
    .clock(clock),
    .resetn(resetn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .irq_o(irq_o),
    .sleep_mode(sleep_mode),
    .output_sample_rate(output_sample_rate),
    .func_event(func_event),
    .irq_one_pending(irq_one_pending),
    .irq_two_pending(irq_two_pending),
    .sample_valid(sample_valid),
    .fifo_empty(fifo_empty),
    .sample_write(sample_write),
    .fifo_flush(fifo_flush),
    .debounce_reset(debounce_reset),
    .func_active(func_active),
    .wake_request(wake_request),
    .irq_line_one_o(irq_line_one_o),
    .irq_line_one_oe(irq_line_one_oe),
    .irq_line_two_o(irq_line_two_o),
    .irq_line_two_oe(irq_line_two_oe)
  );
  swi_host_model swi_host_model_i (
    .clock(clock),
    .resetn(resetn),
    .sample_write(sample_write),
    .fifo_flush(fifo_flush),
    .drain(drain),
    .irq_line_one_o(irq_line_one_o),
    .irq_line_one_oe(irq_line_one_oe),
    .irq_line_two_o(irq_line_two_o),
    .irq_line_two_oe(irq_line_two_oe),
    .fifo_empty(fifo_empty),
    .fifo_count(fifo_count),
    .line_one(line_one),
    .line_two(line_two)
  );
  //////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge clock);
  endtask
  // Values read just after an edge are the ones the edge sampled.
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Only the watchdog ends a wait for an ack that never comes.
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clock);
    chk("ack drop", 0, wb_ack_o);
  endtask
  task automatic fill(int n);
    sample_valid <= 1;
    tk(n);
    sample_valid <= 0;
    tk(4);
  endtask
  task automatic t_regs;
    wb(0, SWI_ADDR_CTRL, 0);
    chk("ctrl reset", 32'h0, rd);
    wb(1, SWI_ADDR_CTRL, 32'hff);
    wb(0, SWI_ADDR_CTRL, 0);
    chk("ctrl rw", 32'hff, rd);
    wb(0, 8'h40, 0);
    chk("unmapped", 32'h0, rd);
    $display("t_regs done");
  endtask
  task automatic t_wake;
    for (int f = 0; f < SWI_NFUNC; f++) begin
      wb(1, SWI_ADDR_CTRL, 32'h4 << f);
      sleep_mode <= 1;
      tk(3);
      chk("active", 32'h1 << f, func_active);
      func_event <= ~(5'h1 << f);
      tk(2);
      chk("no wake", 0, wake_request);
      func_event <= 5'h1 << f;
      tk(2);
      chk("wake", 1, wake_request);
      func_event <= 0;
      sleep_mode <= 0;
      tk(3);
      chk("awake", 32'h1f, func_active);
    end
    $display("t_wake done");
  endtask
  task automatic t_hold;
    wb(1, SWI_ADDR_CTRL, 0);
    fill(3);
    sleep_mode <= 1;
    tk(4);
    chk("flushed", 0, fifo_count);
    wb(1, SWI_ADDR_CTRL, 32'h80);
    wb(1, SWI_ADDR_IMASK, 32'h2);
    fill(2);
    sleep_mode <= 0;
    tk(3);
    fill(1);
    chk("kept", 2, fifo_count);
    chk("irq", 1, irq_o);
    wb(0, SWI_ADDR_STATE, 0);
    chk("gerr", 1, rd[SWI_ST_GERR]);
    chk("held", 1, rd[SWI_ST_HELD]);
    drain <= 1;
    tk(4);
    drain <= 0;
    wb(0, SWI_ADDR_STATE, 0);
    chk("gerr off", 0, rd[SWI_ST_GERR]);
    wb(0, SWI_ADDR_ISTAT, 0);
    chk("istat gerr", 1, rd[SWI_IRQ_GERR]);
    wb(0, SWI_ADDR_ISTAT, 0);
    chk("istat clear", 0, rd);
    tk(2);
    chk("irq off", 0, irq_o);
    fill(1);
    output_sample_rate <= 3'h5;
    tk(3);
    chk("rate flush", 0, fifo_count);
    $display("t_hold done");
  endtask
  task automatic t_aslp;
    logic seen = 0;
    wb(1, SWI_ADDR_CTRL, 0);
    wb(1, SWI_ADDR_CFG, 32'h1);
    fill(1);
    sleep_mode <= 1;
    repeat (4) begin
      @(posedge clock);
      seen |= debounce_reset;
    end
    chk("debounce", 1, seen);
    chk("aslp flush", 0, fifo_count);
    $display("t_aslp done");
  endtask
  task automatic t_pins;
    for (int c = 0; c < 4; c++) begin
      wb(1, SWI_ADDR_CTRL, c);
      irq_one_pending <= 1;
      tk(3);
      chk("line one", c[1], line_one);
      chk("line two", c[0] | !c[1], line_two);
      chk("oe two", !c[0], irq_line_two_oe);
    end
    $display("t_pins done");
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    tk(5);
    resetn <= 1;
    tk(1);
    t_regs;
    t_wake;
    t_hold;
    t_aslp;
    t_pins;
    end_of_test;
  end
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
endmodule
bind swi_sleep_wake_irq_control swi_chk swi_chk_i (
  .clock(clock),
  .resetn(resetn),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .sleep_mode(sleep_mode),
  .output_sample_rate(output_sample_rate),
  .func_event(func_event),
  .func_active(func_active),
  .irq_one_pending(irq_one_pending),
  .irq_two_pending(irq_two_pending),
  .sample_valid(sample_valid),
  .sample_write(sample_write),
  .fifo_flush(fifo_flush),
  .debounce_reset(debounce_reset),
  .wake_request(wake_request),
  .irq_line_one_o(irq_line_one_o),
  .irq_line_one_oe(irq_line_one_oe),
  .irq_line_two_o(irq_line_two_o),
  .irq_line_two_oe(irq_line_two_oe)
);
`default_nettype wire
